// ---- logic/ate_start_status_handshake.sv ----
// Start input and three status outputs toward test equipment, with an AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "ate_handshake_defines.svh"

// Summary of operation
// R1: Each status output is low when its state is active and high when passive.
// R2: The fail output goes low when the current operation ends unsuccessfully.
// R3: The pass output goes low when the current operation finishes without error.
// R4: The busy output stays low for the whole time an operation is executing.
// R5: Pulling the launch input low starts the preset operation, which is programming unless set otherwise.
// R6: A falling edge on the launch input acts exactly like a press of the local launch button.
// R7: A self-test runs whenever one is requested, at any time.
// R8: Busy is released in the same cycle that pass or fail asserts, and pass and fail are never low together.
module ate_start_status_handshake (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic launch_request_n,
  input wire logic launch_button_n,
  output ate_handshake_pkg::status_pins_t status_pins,
  output logic irq
);

  import ate_handshake_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning

  logic req_level_n;
  logic req_fall;
  logic btn_level_n;
  logic btn_fall;

  launch_edge_detect u_req_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_n(launch_request_n),
    .level_n(req_level_n),
    .fall(req_fall)
  );

  // The local button goes through the very same path as the remote request
  launch_edge_detect u_btn_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_n(launch_button_n),
    .level_n(btn_level_n),
    .fall(btn_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  ahb_req_t req;
  logic wr_go;
  logic rd_go;
  logic [`ADDR_BITS-1:0] wr_addr;

  // Capture the address phase; the slave never inserts wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
    end else if (hready) begin
      req.valid <= hsel & htrans[1];
      req.write <= hwrite;
      req.addr <= haddr[`ADDR_BITS-1:0];
    end
  end

  assign wr_go = req.valid & req.write;
  assign rd_go = hsel & htrans[1] & ~hwrite & hready;
  assign wr_addr = req.addr;

  logic ctrl_wr;
  logic irq_clr_wr;
  logic mask_wr;
  assign ctrl_wr = wr_go & (wr_addr == `OFS_CTRL);
  assign irq_clr_wr = wr_go & (wr_addr == `OFS_IRQ_STATUS);
  assign mask_wr = wr_go & (wr_addr == `OFS_IRQ_MASK);

  // Software commands decoded from a control write
  logic sw_start;
  logic sw_selftest;
  logic sw_ok;
  logic sw_fail;
  assign sw_start = ctrl_wr & hwdata[`CTRL_START_BIT];
  assign sw_selftest = ctrl_wr & hwdata[`CTRL_SELFTEST_BIT];
  assign sw_ok = ctrl_wr & hwdata[`CTRL_DONE_OK_BIT];
  assign sw_fail = ctrl_wr & hwdata[`CTRL_DONE_FAIL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Preset operation

  preset_op_t preset_op;
  preset_op_t run_op;

  // Programming is the preset until software picks another
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preset_op <= preset_op_t'(`OP_RESET); // R5
    end else if (ctrl_wr && hwdata[`CTRL_LOAD_OP_BIT]) begin
      preset_op <= preset_op_t'(hwdata[`CTRL_SET_OP_MSB:`CTRL_SET_OP_LSB]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  seq_state_t state;
  logic launch;
  logic st_start;
  logic st_done;
  logic st_ran;

  // Pin edge, button edge and software start are one and the same event
  assign launch = req_fall | btn_fall | sw_start; // R5 R6

  selftest_timer u_selftest (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(st_start),
    .done(st_done)
  );

  // Self-test may be requested in any state; it preempts a running operation
  assign st_start = sw_selftest; // R7

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= st_idle;
      run_op <= op_program;
    end else begin
      case (state)
        st_idle: begin
          if (st_start) begin
            state <= st_selftest;
          end else if (launch) begin
            state <= st_run; // R5
            run_op <= preset_op;
          end
        end
        st_run: begin
          if (st_start) begin
            state <= st_selftest; // R7
          end else if (sw_ok || sw_fail) begin
            state <= st_idle;
          end
        end
        st_selftest: begin
          if (st_done && !st_start) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // Remembers whether a self-test has finished since reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ran <= 1'b0;
    end else if (st_done) begin
      st_ran <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  logic busy;
  logic passed;
  logic failed;
  logic end_ok;
  logic end_fail;

  // Fail wins if software reports both at once; self-test always ends good
  assign end_fail = (state == st_run) & sw_fail & ~st_start;
  assign end_ok = ((state == st_run) & sw_ok & ~sw_fail & ~st_start) | (st_done & ~st_start);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      passed <= 1'b0;
      failed <= 1'b0;
    end else if (st_start || (state == st_idle && launch)) begin
      busy <= 1'b1; // R4
      passed <= 1'b0;
      failed <= 1'b0;
    end else if (end_fail) begin
      busy <= 1'b0; // R8
      passed <= 1'b0;
      failed <= 1'b1; // R2
    end else if (end_ok) begin
      busy <= 1'b0; // R8
      passed <= 1'b1; // R3
      failed <= 1'b0;
    end
  end

  // Pins are the inverted flags, straight from flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_pins <= '1;
    end else begin
      status_pins.active_op_flag_n <= ~(st_start | ((state == st_idle) & launch) |
        (busy & ~end_ok & ~end_fail)); // R1 R4 R8
      status_pins.pass_flag_n <= ~(end_ok | (passed & ~busy & ~st_start & ~launch)); // R1 R3
      status_pins.fail_flag_n <= ~(end_fail | (failed & ~busy & ~st_start & ~launch)); // R1 R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [`IRQ_WIDTH-1:0] irq_event;

  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_LAUNCH_BIT] = (state == st_idle) & launch & ~st_start;
    irq_event[`IRQ_PASS_BIT] = end_ok;
    irq_event[`IRQ_FAIL_BIT] = end_fail;
    irq_event[`IRQ_SELFTEST_BIT] = st_done;
  end

  // A new event outweighs a write-one-to-clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~(irq_clr_wr ? hwdata[`IRQ_WIDTH-1:0] : '0)) | irq_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= `MASK_RESET;
    end else if (mask_wr) begin
      irq_mask <= hwdata[`IRQ_WIDTH-1:0];
    end
  end

  // Registered output lags the status bit by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    case (haddr[`ADDR_BITS-1:0])
      `OFS_STATUS: begin
        next_rdata[`STAT_BUSY_BIT] = busy;
        next_rdata[`STAT_PASS_BIT] = passed;
        next_rdata[`STAT_FAIL_BIT] = failed;
        next_rdata[`STAT_SELFTEST_BIT] = st_ran;
        next_rdata[`STAT_OP_MSB:`STAT_OP_LSB] = preset_op;
        next_rdata[`STAT_PIN_BIT] = req_level_n & btn_level_n;
      end
      `OFS_IRQ_STATUS: next_rdata[`IRQ_WIDTH-1:0] = irq_status;
      `OFS_IRQ_MASK: next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
      `OFS_RESULT: next_rdata[`STAT_OP_MSB:`STAT_OP_LSB] = run_op;
      `OFS_ID: next_rdata = `IDENT_VALUE; // Arbitrary identification value
      default: next_rdata = '0;
    endcase
  end

  // Read data is latched at the address phase and stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_go) begin
      hrdata <= next_rdata;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- logic/ate_handshake_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the start/status handshake
`ifndef ATE_HANDSHAKE_DEFINES_SVH
`define ATE_HANDSHAKE_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00c
`define OFS_RESULT 12'h010
`define OFS_ID 12'h014
`define ADDR_BITS 12

// Control register fields (write 1 pulses, apart from the operation value field)
`define CTRL_START_BIT 0
`define CTRL_SELFTEST_BIT 1
`define CTRL_SET_OP_LSB 4
`define CTRL_SET_OP_MSB 5
`define CTRL_LOAD_OP_BIT 8
`define CTRL_DONE_OK_BIT 16
`define CTRL_DONE_FAIL_BIT 17

// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_PASS_BIT 1
`define STAT_FAIL_BIT 2
`define STAT_SELFTEST_BIT 3
`define STAT_OP_LSB 4
`define STAT_OP_MSB 5
`define STAT_PIN_BIT 8

// Interrupt event bits
`define IRQ_WIDTH 4
`define IRQ_LAUNCH_BIT 0
`define IRQ_PASS_BIT 1
`define IRQ_FAIL_BIT 2
`define IRQ_SELFTEST_BIT 3

// Reset values
`define OP_RESET 2'h0
`define MASK_RESET 4'h0
`define IDENT_VALUE 32'h0000_a5e1

// Self-test length in clock cycles
`define SELFTEST_NS 1000
`define CLK_PERIOD_NS 8
`define SELFTEST_CYCLES ((`SELFTEST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELFTEST_CNT_W 8

`endif

// ---- logic/ate_handshake_pkg.sv ----
// Types shared by the start/status handshake files
package ate_handshake_pkg;

  // Preset operation launched by the start request
  typedef enum logic [1:0] {
    op_program,
    op_erase,
    op_verify,
    op_read
  } preset_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_selftest
  } seq_state_t;

  // Status pins toward the test equipment, all active low
  typedef struct packed {
    logic fail_flag_n;
    logic pass_flag_n;
    logic active_op_flag_n;
  } status_pins_t;

  // AHB-Lite request as sampled at the address phase
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic valid;
  } ahb_req_t;

endpackage

// ---- logic/launch_edge_detect.sv ----
// Two-stage synchroniser and falling-edge detector for the launch request pin
`timescale 1ns/1ns
`default_nettype none

module launch_edge_detect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_n,
  output logic level_n,
  output logic fall
);

  logic sync_a;
  logic sync_b;
  logic prev_b;

  // Idle level is high so the pin reads passive out of reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      prev_b <= 1'b1;
    end else begin
      sync_a <= pin_n;
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end

  // Only the second stage and its delayed copy are looked at, never the first
  assign level_n = sync_b;
  assign fall = prev_b & ~sync_b;

endmodule

`default_nettype wire

// ---- logic/selftest_timer.sv ----
// Down-counter that times one self-test run
`timescale 1ns/1ns
`default_nettype none
`include "ate_handshake_defines.svh"

module selftest_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  output logic done
);

  logic [`SELFTEST_CNT_W-1:0] count;
  logic running;

  // A new start reloads the count, so a repeated request restarts the test
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      running <= 1'b0;
    end else if (start) begin
      count <= `SELFTEST_CNT_W'(`SELFTEST_CYCLES - 1);
      running <= 1'b1;
    end else if (running) begin
      if (count == '0) begin
        running <= 1'b0;
      end else begin
        count <= count - `SELFTEST_CNT_W'(1);
      end
    end
  end

  assign done = running & (count == '0) & ~start;

endmodule

`default_nettype wire

// ---- bench/ate_controller.sv ----
// Test equipment model driving the launch request line
`timescale 1ns/1ns
`default_nettype none
module ate_controller (
  input wire logic hclk,
  input wire logic go,
  input wire logic [3:0] low_cycles,
  output logic launch_request_n
);
  // Pull-up holds the line high between requests
  initial launch_request_n = 1'b1;
  // Low for a chosen span, then high again before any next request
  always @(posedge hclk) begin
    if (go === 1'b1) begin
      launch_request_n <= 1'b0;
      repeat (low_cycles) @(posedge hclk);
      launch_request_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/ate_start_status_handshake_assertions.sv ----
// Port checker for the start/status handshake
`timescale 1ns/1ns
`default_nettype none
module ate_handshake_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic launch_request_n,
  input wire logic launch_button_n,
  input wire ate_handshake_pkg::status_pins_t status_pins
);
  import ate_handshake_pkg::*;
  logic busy_n;
  logic pass_n;
  logic fail_n;
  // Short names for the pins
  assign busy_n = status_pins.active_op_flag_n;
  assign pass_n = status_pins.pass_flag_n;
  assign fail_n = status_pins.fail_flag_n;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Verdicts
  property p_excl; !(!pass_n && !fail_n); endproperty
  a_excl: assert property (p_excl) else $error("pass and fail low together");
  property p_end; $rose(busy_n) |-> !pass_n || !fail_n; endproperty
  a_end: assert property (p_end) else $error("busy ended without verdict");
  property p_clr; $fell(busy_n) |-> pass_n && fail_n; endproperty
  a_clr: assert property (p_clr) else $error("old verdict kept at start");
  property p_pc; $fell(pass_n) |-> $rose(busy_n); endproperty
  a_pc: assert property (p_pc) else $error("pass without end of op");
  property p_fc; $fell(fail_n) |-> $rose(busy_n); endproperty
  a_fc: assert property (p_fc) else $error("fail without end of op");
  // A verdict stays until the next operation starts
  property p_ph; !pass_n && busy_n |=> !pass_n || !busy_n; endproperty
  a_ph: assert property (p_ph) else $error("pass dropped while idle");
  property p_fh; !fail_n && busy_n |=> !fail_n || !busy_n; endproperty
  a_fh: assert property (p_fh) else $error("fail dropped while idle");
  // Launch from idle; sync delay sets the window
  property p_lr; $fell(launch_request_n) && busy_n |-> ##[2:6] !busy_n; endproperty
  a_lr: assert property (p_lr) else $error("request did not launch");
  property p_lb; $fell(launch_button_n) && busy_n |-> ##[2:6] !busy_n; endproperty
  a_lb: assert property (p_lb) else $error("button did not launch");
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready or not okay");
endmodule
bind ate_start_status_handshake ate_handshake_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .launch_request_n(launch_request_n),
  .launch_button_n(launch_button_n), .status_pins(status_pins));
`default_nettype wire

// ---- bench/ate_start_status_handshake_tb.sv ----
// Self-checking bench for the start/status handshake
`timescale 1ns/1ns
`default_nettype none
`include "ate_handshake_defines.svh"
module ate_start_status_handshake_tb;
  import ate_handshake_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic launch_button_n = 1'b1;
  logic go = 1'b0;
  logic [3:0] low_cycles = 4'h1;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic launch_request_n;
  logic irq;
  status_pins_t status_pins;
  logic [31:0] rd;
  logic [1:0] v;
  logic mb = 1'b0, mp = 1'b0, mf = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 72082;
  int n;
  int q_op[$];
  always #4 hclk = ~hclk;
  ate_start_status_handshake DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .launch_request_n(launch_request_n),
    .launch_button_n(launch_button_n), .status_pins(status_pins), .irq(irq));
  ate_controller ate (.hclk(hclk), .go(go), .low_cycles(low_cycles),
    .launch_request_n(launch_request_n));
  ////////////////////////////////////////////////////////////////
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // One single transfer; hready is polled, no latency assumed
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Let the edge's updates land before looking
  task pins();
    #1 chk("pins", {29'h0, ~mf, ~mp, ~mb}, {29'h0, status_pins});
  endtask
  task wait_busy(input logic b, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge hclk);
      if (status_pins.active_op_flag_n === b) break;
    end
  endtask
  // Odd runs start from the button, even ones from the controller
  task launch(input int k);
    if (k % 2 == 1) begin
      launch_button_n <= 1'b0;
      repeat (3) @(posedge hclk);
      launch_button_n <= 1'b1;
    end else begin
      low_cycles <= (4'($random(seed)) & 4'h7) + 4'h1;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
    end
    wait_busy(1'b0, 12);
    mb = 1'b1;
    mp = 1'b0;
    mf = 1'b0;
    pins();
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run
  initial begin
    #40000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    pins();
    chk("irq", 32'h0, 32'(irq));
    bus(1'b0, `OFS_ID, 32'h0);
    chk("id", `IDENT_VALUE, rd);
    bus(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Every preset op, first the reset default, each ending at random
    for (int k = 0; k < 4; k++) begin
      if (k > 0) bus(1'b1, `OFS_CTRL, 32'(k << 4) | 32'h100);
      launch(k);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk("status", 32'(k << 4) | 32'h1, rd & 32'h3f);
      v = 2'($random(seed));
      if (v == 2'h0) v = 2'h1;
      bus(1'b1, `OFS_CTRL, 32'(v) << 16);
      mb = 1'b0;
      mf = v[1];
      mp = ~v[1];
      pins();
      q_op.push_back(k);
      bus(1'b0, `OFS_RESULT, 32'h0);
      chk("result", 32'(q_op[$] << 4), rd & 32'h30);
    end
    // Interrupt raised, masked, cleared
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    @(posedge hclk);
    #1 chk("irq_on", 32'h1, 32'(irq));
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    @(posedge hclk);
    #1 chk("irq_mask", 32'h0, 32'(irq));
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `OFS_IRQ_STATUS, 32'hf);
    @(posedge hclk);
    #1 chk("irq_clr", 32'h0, 32'(irq));
    // Self-test requested in mid-run takes over
    launch(0);
    bus(1'b1, `OFS_CTRL, 32'h2);
    wait_busy(1'b1, 200);
    chk("st_len", 32'h1, 32'(n > 118 && n < 132));
    mb = 1'b0;
    mp = 1'b1;
    pins();
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("st_done", 32'h8, rd & 32'h8);
    end_of_test();
  end
endmodule
`default_nettype wire
